// *** cpu_core_register_context.sv ***
`timescale 1ns/1ps
// Functional notes
// (RULE1) 8-bit accumulator, also read and written as data-space location FFh.
// (RULE2) Two pointer registers appear at data-space locations 80h and 81h.
// (RULE3) Two short-direct registers appear at data-space locations 82h and 83h.
// (RULE4) Program counter is 12 bits, covering 4096 bytes of program space.
// (RULE5) Program counter increments after the current instruction address is read.
// (RULE6) Relative branch adds signed offset to program counter and writes it back.
// (RULE7) PC loads jump, call, relative, vectors, stack pop or PC+1.
// (RULE8) Three carry/zero pairs, one per context; only the current pair is used.
// (RULE9) Interrupt entry selects interrupt pair, NMI its pair; return restores previous.
// (RULE10) Context switches keep all pairs; a pair is accessed only in its context.
// (RULE11) Carry takes arithmetic carry, tested bit, or shifts through rotate-left.
// (RULE12) Zero set when last arithmetic or logic result is zero.
// (RULE13) After reset the NMI context and its flag pair are active.
// (RULE14) Return stack has six 12-bit levels outside data space.
// (RULE15) Call or interrupt pushes PC; the sixth level value is dropped.
// (RULE16) Return pops the first level into PC and shifts deeper levels up.
// (RULE17) More than six nestings keep the stack at its deepest position.
// (RULE18) Return on empty stack keeps stack at top; execution continues sequentially; the code holds PC unchanged.
// (RULE19) Reset empties the stack and loads PC with the reset vector.
// (RULE20) The chain of active contexts is recorded for each return from interrupt; the code keeps only the two most recent previous contexts.
module cpu_core_register_context
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] ds_addr_i,
  input wire logic ds_wr_i,
  input wire logic ds_rd_i,
  input wire logic [cpu_ctx_pkg::DATA_W-1:0] ds_wdata_i,
  output logic [cpu_ctx_pkg::DATA_W-1:0] ds_rdata_o,
  output logic ds_hit_o,
  input wire cpu_ctx_pkg::pc_src_e pc_src_i,
  input wire logic [cpu_ctx_pkg::PC_W-1:0] pc_target_i,
  input wire logic [7:0] pc_offset_i,
  input wire logic [cpu_ctx_pkg::PC_W-1:0] int_vector_i,
  input wire cpu_ctx_pkg::flag_op_e flag_op_i,
  input wire logic [cpu_ctx_pkg::DATA_W-1:0] alu_result_i,
  input wire logic alu_carry_i,
  input wire logic tested_bit_i,
  input wire logic flag_carry_i,
  input wire logic flag_zero_i,
  input wire logic acc_we_i,
  output logic [cpu_ctx_pkg::PC_W-1:0] program_counter_o,
  output logic [cpu_ctx_pkg::DATA_W-1:0] accumulator_o,
  output logic [cpu_ctx_pkg::DATA_W-1:0] pointer_first_o,
  output logic [cpu_ctx_pkg::DATA_W-1:0] pointer_second_o,
  output logic carry_o,
  output logic zero_o,
  output cpu_ctx_pkg::ctx_e ctx_o,
  output logic [cpu_ctx_pkg::DEPTH_W-1:0] stack_depth_o
);
  import cpu_ctx_pkg::*;

  typedef struct packed
  {
    logic [PC_W-1:0] program_counter;
    logic [DATA_W-1:0] accumulator;
    logic [DATA_W-1:0] pointer_reg_first;
    logic [DATA_W-1:0] pointer_reg_second;
    logic [DATA_W-1:0] short_direct_reg_first;
    logic [DATA_W-1:0] short_direct_reg_second;
    logic [2:0] carry_ctx;
    logic [2:0] zero_ctx;
    ctx_e ctx;
    ctx_e ctx_prev_first;
    ctx_e ctx_prev_second;
    logic [STACK_LEVELS-1:0][PC_W-1:0] stack; // RULE14
    logic [DEPTH_W-1:0] depth;
    logic [DATA_W-1:0] rdata;
    logic hit;
    logic carry_cur;
    logic zero_cur;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Sign-extended offset added to the program counter
  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc,
                                             input logic [7:0] off);
    pc_add = pc + {{(PC_W-8){off[7]}}, off};
  endfunction

  // Readable data-space location
  function automatic logic ds_mapped(input logic [7:0] a);
    ds_mapped = (a == ADDR_ACCUMULATOR) || (a == ADDR_POINTER_FIRST) ||
                (a == ADDR_POINTER_SECOND) || (a == ADDR_SHORT_FIRST) ||
                (a == ADDR_SHORT_SECOND);
  endfunction

  logic push;
  logic pop;
  logic [1:0] ci;
  logic [DATA_W-1:0] acc_cur;

  always_comb
  begin
    st_nxt = st_r;
    push = (pc_src_i == PC_CALL) || (pc_src_i == PC_INT) || (pc_src_i == PC_NMI);
    pop = (pc_src_i == PC_RET) || (pc_src_i == PC_RETURN_FROM_INTERRUPT);
    ci = st_r.ctx; // RULE8
    acc_cur = st_r.accumulator;

    // Program counter sources
    case (pc_src_i)
      PC_HOLD: st_nxt.program_counter = st_r.program_counter;
      PC_INC: st_nxt.program_counter = st_r.program_counter + PC_ONE; // RULE5
      PC_JUMP: st_nxt.program_counter = pc_target_i; // RULE7
      PC_CALL: st_nxt.program_counter = pc_target_i; // RULE7
      PC_REL: st_nxt.program_counter = pc_add(st_r.program_counter, pc_offset_i); // RULE6
      PC_INT: st_nxt.program_counter = int_vector_i; // RULE7
      PC_NMI: st_nxt.program_counter = NMI_VECTOR; // RULE7
      PC_RET, PC_RETURN_FROM_INTERRUPT:
      begin
        if (st_r.depth != '0)
        begin
          st_nxt.program_counter = st_r.stack[0]; // RULE16
        end
        else
        begin
          st_nxt.program_counter = st_r.program_counter; // RULE18
        end
      end
      default: st_nxt.program_counter = st_r.program_counter;
    endcase

    // Return stack
    if (push)
    begin
      for (int i = STACK_LEVELS - 1; i > 0; i--)
      begin
        st_nxt.stack[i] = st_r.stack[i-1]; // RULE15
      end
      st_nxt.stack[0] = st_r.program_counter; // RULE15
      if (st_r.depth != DEPTH_W'(STACK_LEVELS))
      begin
        st_nxt.depth = st_r.depth + 3'h1;
      end // RULE17
    end
    else if (pop && (st_r.depth != '0))
    begin
      for (int i = 0; i < STACK_LEVELS - 1; i++)
      begin
        st_nxt.stack[i] = st_r.stack[i+1]; // RULE16
      end
      st_nxt.depth = st_r.depth - 3'h1;
    end

    // Context chain
    if (pc_src_i == PC_INT)
    begin
      st_nxt.ctx = CTX_INTERRUPT; // RULE9
      st_nxt.ctx_prev_first = st_r.ctx; // RULE20
      st_nxt.ctx_prev_second = st_r.ctx_prev_first;
    end
    else if (pc_src_i == PC_NMI)
    begin
      st_nxt.ctx = CTX_NONMASKABLE; // RULE9
      st_nxt.ctx_prev_first = st_r.ctx; // RULE20
      st_nxt.ctx_prev_second = st_r.ctx_prev_first;
    end
    else if (pc_src_i == PC_RETURN_FROM_INTERRUPT)
    begin
      st_nxt.ctx = st_r.ctx_prev_first; // RULE9 RULE20
      st_nxt.ctx_prev_first = st_r.ctx_prev_second;
      st_nxt.ctx_prev_second = CTX_NORMAL;
    end

    // Accumulator from the ALU side
    if (acc_we_i)
    begin
      st_nxt.accumulator = alu_result_i;
    end

    // Flags of the current context only
    case (flag_op_i)
      FLG_NONE:
      begin
        st_nxt.carry_ctx = st_r.carry_ctx;
      end
      FLG_ARITH:
      begin
        st_nxt.carry_ctx[ci] = alu_carry_i; // RULE11 RULE8
        st_nxt.zero_ctx[ci] = (alu_result_i == '0); // RULE12
      end
      FLG_LOGIC:
      begin
        st_nxt.zero_ctx[ci] = (alu_result_i == '0); // RULE12
      end
      FLG_BITTEST:
      begin
        st_nxt.carry_ctx[ci] = tested_bit_i; // RULE11
      end
      FLG_ROTATE:
      begin
        st_nxt.carry_ctx[ci] = acc_cur[7]; // RULE11
        st_nxt.accumulator = {acc_cur[6:0], st_r.carry_ctx[ci]};
        st_nxt.zero_ctx[ci] = ({acc_cur[6:0], st_r.carry_ctx[ci]} == '0);
      end
      FLG_LOAD:
      begin
        st_nxt.carry_ctx[ci] = flag_carry_i; // RULE10
        st_nxt.zero_ctx[ci] = flag_zero_i;
      end
      default:
      begin
        st_nxt.carry_ctx = st_r.carry_ctx;
      end
    endcase

    // Data-space writes win over the ALU path
    if (ds_wr_i)
    begin
      case (ds_addr_i)
        ADDR_ACCUMULATOR: st_nxt.accumulator = ds_wdata_i; // RULE1
        ADDR_POINTER_FIRST: st_nxt.pointer_reg_first = ds_wdata_i; // RULE2
        ADDR_POINTER_SECOND: st_nxt.pointer_reg_second = ds_wdata_i; // RULE2
        ADDR_SHORT_FIRST: st_nxt.short_direct_reg_first = ds_wdata_i; // RULE3
        ADDR_SHORT_SECOND: st_nxt.short_direct_reg_second = ds_wdata_i; // RULE3
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    // Data-space reads, zero for unmapped locations
    st_nxt.hit = ds_rd_i && ds_mapped(ds_addr_i);
    st_nxt.rdata = '0;
    if (ds_rd_i)
    begin
      case (ds_addr_i)
        ADDR_ACCUMULATOR: st_nxt.rdata = st_r.accumulator; // RULE1
        ADDR_POINTER_FIRST: st_nxt.rdata = st_r.pointer_reg_first; // RULE2
        ADDR_POINTER_SECOND: st_nxt.rdata = st_r.pointer_reg_second; // RULE2
        ADDR_SHORT_FIRST: st_nxt.rdata = st_r.short_direct_reg_first; // RULE3
        ADDR_SHORT_SECOND: st_nxt.rdata = st_r.short_direct_reg_second; // RULE3
        default: st_nxt.rdata = '0;
      endcase
    end

    // Registered copy of the active pair
    st_nxt.carry_cur = st_nxt.carry_ctx[st_nxt.ctx]; // RULE8
    st_nxt.zero_cur = st_nxt.zero_ctx[st_nxt.ctx];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.program_counter <= RESET_VECTOR; // RULE19
      st_r.depth <= '0; // RULE19
      st_r.ctx <= CTX_NONMASKABLE; // RULE13
      st_r.ctx_prev_first <= CTX_NORMAL;
      st_r.ctx_prev_second <= CTX_NORMAL;
      st_r.accumulator <= REG_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign program_counter_o = st_r.program_counter; // RULE4
  assign accumulator_o = st_r.accumulator;
  assign pointer_first_o = st_r.pointer_reg_first;
  assign pointer_second_o = st_r.pointer_reg_second;
  assign carry_o = st_r.carry_cur; // RULE8
  assign zero_o = st_r.zero_cur;
  assign ctx_o = st_r.ctx;
  assign stack_depth_o = st_r.depth;
  assign ds_rdata_o = st_r.rdata;
  assign ds_hit_o = st_r.hit;

  AST_RESET_STATE: assert property (@(posedge clk_i) // RULE19
    sys_rst_i |=> (program_counter_o == RESET_VECTOR) && (stack_depth_o == '0)
                  && (ctx_o == CTX_NONMASKABLE))
    else $error("reset state wrong");

  AST_PC_INC: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
    (pc_src_i == PC_INC) |=> (program_counter_o == $past(program_counter_o) + PC_ONE))
    else $error("pc did not increment");

  AST_PC_REL: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE6
    (pc_src_i == PC_REL) |=>
      (program_counter_o == pc_add($past(program_counter_o), $past(pc_offset_i))))
    else $error("relative branch wrong");

  AST_CALL_PUSH: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE15
    (pc_src_i == PC_CALL) |=> (st_r.stack[0] == $past(program_counter_o))
      && (program_counter_o == $past(pc_target_i)))
    else $error("call did not push");

  AST_RET_POP: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE16
    ((pc_src_i == PC_CALL) ##1 (pc_src_i == PC_RET)) |=>
      (program_counter_o == $past(program_counter_o, 2)))
    else $error("return address lost");

  AST_DEEP_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE17
    ((pc_src_i == PC_CALL) && (stack_depth_o == 3'd6)) |=> (stack_depth_o == 3'd6))
    else $error("stack grew past six");

  AST_EMPTY_RET: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE18
    ((pc_src_i == PC_RET) && (stack_depth_o == '0)) |=>
      (stack_depth_o == '0) && $stable(program_counter_o))
    else $error("empty return misbehaved");

  AST_CTX_RETURN: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE9
    ((pc_src_i == PC_INT) ##1 (pc_src_i == PC_RETURN_FROM_INTERRUPT)) |=> (ctx_o == $past(ctx_o, 2)))
    else $error("context not restored");

  AST_FLAGS_KEPT: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE10
    (pc_src_i == PC_INT) && (flag_op_i == FLG_NONE) |=> $stable(st_r.carry_ctx)
      && $stable(st_r.zero_ctx))
    else $error("flags changed on switch");

  AST_ZERO_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE12
    (flag_op_i == FLG_ARITH) && (pc_src_i == PC_HOLD) |=>
      (zero_o == ($past(alu_result_i) == '0)) && (carry_o == $past(alu_carry_i)))
    else $error("flags not from result");

  AST_ACC_DS: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE1
    (ds_wr_i && (ds_addr_i == ADDR_ACCUMULATOR)) ##1 (ds_rd_i && !ds_wr_i
      && (ds_addr_i == ADDR_ACCUMULATOR) && !acc_we_i && (flag_op_i != FLG_ROTATE))
      |=> ds_hit_o && (ds_rdata_o == $past(ds_wdata_i, 2)))
    else $error("accumulator not at FFh");

  AST_NMI_ENTRY: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE9
    (pc_src_i == PC_NMI) |=> (ctx_o == CTX_NONMASKABLE) && (program_counter_o == NMI_VECTOR))
    else $error("nmi entry wrong");

  AST_INT_ENTRY: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
    (pc_src_i == PC_INT) |=> (ctx_o == CTX_INTERRUPT) && (program_counter_o == $past(int_vector_i)))
    else $error("interrupt entry wrong");

  AST_BITTEST: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
    (flag_op_i == FLG_BITTEST) && (pc_src_i == PC_HOLD) |=> (carry_o == $past(tested_bit_i)))
    else $error("bit test carry wrong");

  AST_POINTER_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    ds_wr_i && (ds_addr_i == ADDR_POINTER_FIRST) |=> (pointer_first_o == $past(ds_wdata_i)))
    else $error("pointer write lost");

endmodule

// *** cpu_ctx_pkg.sv ***
package cpu_ctx_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int STACK_LEVELS = 6;
  localparam int DEPTH_W = 3;

  localparam logic [7:0] ADDR_POINTER_FIRST = 8'h80;
  localparam logic [7:0] ADDR_POINTER_SECOND = 8'h81;
  localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hff;

  localparam logic [11:0] RESET_VECTOR = 12'hffe;
  localparam logic [11:0] NMI_VECTOR = 12'hffc;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PC_ONE = 12'h001;

  typedef enum logic [1:0]
  {
    CTX_NORMAL = 2'b00,
    CTX_INTERRUPT = 2'b01,
    CTX_NONMASKABLE = 2'b10
  } ctx_e;

  typedef enum logic [3:0]
  {
    PC_HOLD = 4'b0000,
    PC_INC = 4'b0001,
    PC_JUMP = 4'b0010,
    PC_CALL = 4'b0011,
    PC_REL = 4'b0100,
    PC_INT = 4'b0101,
    PC_NMI = 4'b0110,
    PC_RET = 4'b0111,
    PC_RETURN_FROM_INTERRUPT = 4'b1000
  } pc_src_e;

  typedef enum logic [2:0]
  {
    FLG_NONE = 3'b000,
    FLG_ARITH = 3'b001,
    FLG_LOGIC = 3'b010,
    FLG_BITTEST = 3'b011,
    FLG_ROTATE = 3'b100,
    FLG_LOAD = 3'b101
  } flag_op_e;

endpackage

// *** cpu_core_register_context_tb.sv ***
`timescale 1ns/1ps
module cpu_core_register_context_tb;
  import cpu_ctx_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] ds_addr_i = 8'h00;
  logic ds_wr_i = 1'b0;
  logic ds_rd_i = 1'b0;
  logic [7:0] ds_wdata_i = 8'h00;
  pc_src_e pc_src_i = PC_HOLD;
  logic [11:0] pc_target_i = 12'h000;
  logic [7:0] pc_offset_i = 8'h00;
  logic [11:0] int_vector_i = 12'h000;
  flag_op_e flag_op_i = FLG_NONE;
  logic [7:0] alu_result_i = 8'h00;
  logic alu_carry_i = 1'b0;
  logic tested_bit_i = 1'b0;
  logic flag_carry_i = 1'b0;
  logic flag_zero_i = 1'b0;
  logic acc_we_i = 1'b0;
  logic [7:0] ds_rdata_o;
  logic ds_hit_o;
  logic [11:0] program_counter_o;
  logic [7:0] accumulator_o;
  logic [7:0] pointer_first_o;
  logic [7:0] pointer_second_o;
  logic carry_o;
  logic zero_o;
  ctx_e ctx_o;
  logic [2:0] stack_depth_o;
  int err_total = 0;
  int n_tests = 0;

  cpu_core_register_context DUT
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ds_addr_i(ds_addr_i), .ds_wr_i(ds_wr_i),
    .ds_rd_i(ds_rd_i), .ds_wdata_i(ds_wdata_i), .ds_rdata_o(ds_rdata_o),
    .ds_hit_o(ds_hit_o), .pc_src_i(pc_src_i), .pc_target_i(pc_target_i),
    .pc_offset_i(pc_offset_i), .int_vector_i(int_vector_i), .flag_op_i(flag_op_i),
    .alu_result_i(alu_result_i), .alu_carry_i(alu_carry_i), .tested_bit_i(tested_bit_i),
    .flag_carry_i(flag_carry_i), .flag_zero_i(flag_zero_i), .acc_we_i(acc_we_i),
    .program_counter_o(program_counter_o), .accumulator_o(accumulator_o),
    .pointer_first_o(pointer_first_o), .pointer_second_o(pointer_second_o),
    .carry_o(carry_o), .zero_o(zero_o), .ctx_o(ctx_o), .stack_depth_o(stack_depth_o)
  );

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("errors %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Program counter, depth, context and current flag pair
  task automatic st(input logic [11:0] p, input logic [2:0] d, input logic [1:0] x,
                    input logic c, input logic z);
    chk(program_counter_o, p);
    chk(stack_depth_o, d);
    chk(ctx_o, x);
    chk(carry_o, c);
    chk(zero_o, z);
  endtask

  // One command cycle, then back to idle
  task automatic op(input pc_src_e s, input logic [11:0] t, input flag_op_e f,
                    input logic [7:0] r, input logic c, input logic z, input logic we);
    @(posedge clk_i);
    pc_src_i <= s;
    pc_target_i <= t;
    pc_offset_i <= t[7:0];
    int_vector_i <= t;
    flag_op_i <= f;
    alu_result_i <= r;
    alu_carry_i <= c;
    tested_bit_i <= c;
    flag_carry_i <= c;
    flag_zero_i <= z;
    acc_we_i <= we;
    @(posedge clk_i);
    pc_src_i <= PC_HOLD;
    flag_op_i <= FLG_NONE;
    acc_we_i <= 1'b0;
    #1;
  endtask

  task automatic pc(input pc_src_e s, input logic [11:0] t);
    op(s, t, FLG_NONE, 8'h00, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic fl(input flag_op_e f, input logic [7:0] r, input logic c, input logic z);
    op(PC_HOLD, 12'h000, f, r, c, z, 1'b0);
  endtask

  // Data-space access; a read is checked against hit and data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic h);
    @(posedge clk_i);
    ds_addr_i <= a;
    ds_wdata_i <= d;
    ds_wr_i <= wr;
    ds_rd_i <= !wr;
    @(posedge clk_i);
    ds_wr_i <= 1'b0;
    ds_rd_i <= 1'b0;
    #1;
    if (!wr)
    begin
      chk(ds_hit_o, h);
      chk(ds_rdata_o, d);
    end
  endtask

  // Two program-counter commands on consecutive edges
  task automatic pc2(input pc_src_e s1, input logic [11:0] t1, input pc_src_e s2);
    @(posedge clk_i);
    pc_src_i <= s1;
    pc_target_i <= t1;
    int_vector_i <= t1;
    @(posedge clk_i);
    pc_src_i <= s2;
    @(posedge clk_i);
    pc_src_i <= PC_HOLD;
    #1;
  endtask

  // Write then read back on consecutive edges
  task automatic bus2(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ds_addr_i <= a;
    ds_wdata_i <= d;
    ds_wr_i <= 1'b1;
    @(posedge clk_i);
    ds_wr_i <= 1'b0;
    ds_rd_i <= 1'b1;
    @(posedge clk_i);
    ds_rd_i <= 1'b0;
    #1;
    chk(ds_hit_o, 1'b1);
    chk(ds_rdata_o, d);
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial
  begin
    logic [7:0] a[5];
    int i;
    a = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    st(12'hffe, 3'd0, 2'd2, 1'b0, 1'b0);
    chk(accumulator_o, 8'h00);
    for (i = 0; i < 5; i++)
      bus(1'b1, a[i], 8'ha1 + 8'(i), 1'b0);
    for (i = 0; i < 5; i++)
      bus(1'b0, a[i], 8'ha1 + 8'(i), 1'b1);
    chk(pointer_first_o, 8'ha1);
    chk(pointer_second_o, 8'ha2);
    chk(accumulator_o, 8'ha5);
    bus(1'b1, 8'h7f, 8'h33, 1'b0);
    bus(1'b0, 8'h7f, 8'h00, 1'b0);
    bus(1'b0, 8'h84, 8'h00, 1'b0);
    fl(FLG_LOAD, 8'h00, 1'b1, 1'b0);
    st(12'hffe, 3'd0, 2'd2, 1'b1, 1'b0);
    pc(PC_INC, 12'h000);
    chk(program_counter_o, 12'hfff);
    pc(PC_INC, 12'h000);
    chk(program_counter_o, 12'h000);
    pc(PC_JUMP, 12'h123);
    chk(program_counter_o, 12'h123);
    pc(PC_REL, 12'h0fe);
    chk(program_counter_o, 12'h121);
    pc(PC_REL, 12'h005);
    chk(program_counter_o, 12'h126);
    pc(PC_RETURN_FROM_INTERRUPT, 12'h000);
    st(12'h126, 3'd0, 2'd0, 1'b0, 1'b0);
    fl(FLG_ARITH, 8'h00, 1'b1, 1'b0);
    st(12'h126, 3'd0, 2'd0, 1'b1, 1'b1);
    fl(FLG_LOGIC, 8'h3c, 1'b1, 1'b0);
    chk(zero_o, 1'b0);
    fl(FLG_BITTEST, 8'h00, 1'b0, 1'b0);
    chk(carry_o, 1'b0);
    fl(FLG_ROTATE, 8'h00, 1'b0, 1'b0);
    chk(accumulator_o, 8'h4a);
    chk(carry_o, 1'b1);
    fl(FLG_ROTATE, 8'h00, 1'b0, 1'b0);
    chk(accumulator_o, 8'h95);
    chk(carry_o, 1'b0);
    op(PC_HOLD, 12'h000, FLG_LOAD, 8'h00, 1'b0, 1'b1, 1'b1);
    chk(accumulator_o, 8'h00);
    pc(PC_INT, 12'h0f0);
    st(12'h0f0, 3'd1, 2'd1, 1'b0, 1'b0);
    fl(FLG_LOAD, 8'h00, 1'b1, 1'b1);
    pc(PC_NMI, 12'h000);
    st(12'hffc, 3'd2, 2'd2, 1'b1, 1'b0);
    pc(PC_RETURN_FROM_INTERRUPT, 12'h000);
    st(12'h0f0, 3'd1, 2'd1, 1'b1, 1'b1);
    pc(PC_RETURN_FROM_INTERRUPT, 12'h000);
    st(12'h126, 3'd0, 2'd0, 1'b0, 1'b1);
    for (i = 1; i < 8; i++)
    begin
      pc(PC_CALL, 12'h200 + 12'(i));
      st(12'h200 + 12'(i), (i > 6) ? 3'd6 : 3'(i), 2'd0, 1'b0, 1'b1);
    end
    for (i = 6; i > 0; i--)
    begin
      pc(PC_RET, 12'h000);
      st(12'h200 + 12'(i), 3'(i - 1), 2'd0, 1'b0, 1'b1);
    end
    pc(PC_RET, 12'h000);
    st(12'h201, 3'd0, 2'd0, 1'b0, 1'b1);
    pc2(PC_CALL, 12'h345, PC_RET);
    st(12'h201, 3'd0, 2'd0, 1'b0, 1'b1);
    pc2(PC_INT, 12'h0e0, PC_RETURN_FROM_INTERRUPT);
    st(12'h201, 3'd0, 2'd0, 1'b0, 1'b1);
    bus2(8'hff, 8'h5a);
    chk(accumulator_o, 8'h5a);
    bus2(8'h82, 8'hc3);
    pc(PC_CALL, 12'h300);
    st(12'h300, 3'd1, 2'd0, 1'b0, 1'b1);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    st(12'hffe, 3'd0, 2'd2, 1'b0, 1'b0);
    chk(accumulator_o, 8'h00);
    pc(PC_INC, 12'h000);
    chk(program_counter_o, 12'hfff);
    summarize();
  end
endmodule
